// File: hdl/flag_stack_prefix_add_decode.sv
// Summary of operation
// - opcode 9d restores flags, 8 or 12 clocks
// - four segment prefixes, two clocks each
// - add register with reg/mem, 3 or 10
// - adc three forms: 3/10, 4/16, 3/4
// - 001010dw subtract reg/mem, 3 or 10
// - narrow bus word memory adds four clocks
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module flag_stack_prefix_add_decode (
  input wire logic clock_i, // 40 MHz core clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic ce_i, // clock enable, low freezes all state
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [3:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic [7:0] byte_i, // byte from prefetch queue
  input wire logic byte_valid_i, // queue byte present
  output logic byte_ready_o, // decoder takes the byte
  output decode_pkg::decoded_s dec_o, // decoded instruction
  output logic dec_valid_o, // decoded instruction present
  input wire logic dec_ready_i // execution unit takes it
);
  import decode_pkg::*;

  // decode sequencer states
  typedef enum logic [2:0] {
    ST_OPCODE, ST_MODRM, ST_DISP_LO, ST_DISP_HI, ST_IMM_LO, ST_IMM_HI, ST_COST, ST_EMIT
  } state_e;

  state_e state_q; // sequencer state
  state_e state_d; // next state
  decoded_s rec_q; // record under construction
  decoded_s rec_d; // next record
  logic [1:0] ctrl_q; // narrow bus and enable bits
  logic [15:0] count_q; // instructions emitted
  logic pend_q; // override waiting for next instruction
  logic pend_d; // next pending flag
  seg_e pend_seg_q; // segment of waiting override
  seg_e pend_seg_d; // next waiting segment
  logic [31:0] rdat_q; // read data register
  logic ack_q; // acknowledge register

  // bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !ack_q; // new access, ack drops after one cycle
  wire wr_ctrl = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == CTRL_OFS);
  wire wr_count = bus_req && wb_we_i && (wb_adr_i == COUNT_OFS);
  wire narrow = ctrl_q[CTRL_NARROW_BIT]; // 8-bit bus variant
  wire enable = ctrl_q[CTRL_ENABLE_BIT]; // decoder runs

  // byte handshake
  wire want_byte = (state_q != ST_COST) && (state_q != ST_EMIT);
  wire take = ce_i && enable && byte_valid_i && want_byte;
  wire emit_done = ce_i && (state_q == ST_EMIT) && dec_ready_i;

  // opcode classes
  wire [7:0] b = byte_i;
  wire is_prefix = (b == OP_CODE_OVR) || (b == OP_STACK_OVR) || (b == OP_DATA_OVR)
                   || (b == OP_EXTRA_OVR);
  wire is_flags = (b == OP_RESTORE_FLAGS);
  wire is_add_rm = (b[7:2] == OP_ADD_RM);
  wire is_adc_rm = (b[7:2] == OP_ADC_RM);
  wire is_sub_rm = (b[7:2] == OP_SUB_RM);
  wire is_grp = (b[7:2] == OP_IMM_GROUP);
  wire is_add_acc = (b[7:1] == OP_ADD_ACC);
  wire is_adc_acc = (b[7:1] == OP_ADC_ACC);

  // addressing byte: displacement length from mode and rm
  wire direct = (b[7:6] == 2'h0) && (b[2:0] == 3'h6);
  wire disp1 = (b[7:6] == 2'h1);
  wire disp2 = (b[7:6] == 2'h2) || direct;
  wire rec_disp2 = (rec_q.mode == 2'h2) || ((rec_q.mode == 2'h0) && (rec_q.rm == 3'h6));
  wire is_grp_rec = (rec_q.form == FORM_IMM_RM);
  // two immediate bytes for a word operand unless sign extended from one, else one byte
  wire imm_two = rec_q.wide && !rec_q.sext;

  // cost of the finished record
  wire mem_op = (rec_q.form == FORM_RM || rec_q.form == FORM_IMM_RM)
                && (rec_q.mode != MOD_REG);
  logic [4:0] base_cyc; // clocks before the bus penalty
  logic [4:0] cost; // total clocks
  always_comb
  begin
    case (rec_q.form)
      FORM_RM: base_cyc = mem_op ? CYC_RM_MEM : CYC_RM_REG;
      FORM_IMM_RM: base_cyc = mem_op ? CYC_IMM_MEM : CYC_IMM_REG;
      FORM_IMM_ACC: base_cyc = rec_q.wide ? CYC_ACC_WORD : CYC_ACC_BYTE;
      default: base_cyc = 5'h00;
    endcase
    if (rec_q.kind == KIND_RESTORE_FLAGS)
    begin
      base_cyc = narrow ? CYC_FLAGS_NARROW : CYC_FLAGS_WIDE;
    end
    else if (rec_q.kind == KIND_UNKNOWN)
    begin
      // unsupported encodings carry no cost
      base_cyc = 5'h00;
    end
    // word memory on narrow bus
    // unsupported encodings stay at zero, so the penalty never lands on them
    cost = (narrow && mem_op && rec_q.wide && (rec_q.kind != KIND_UNKNOWN))
           ? 5'(base_cyc + CYC_NARROW_WORD) : base_cyc;
  end

  // sequencer and record assembly
  always_comb
  begin
    state_d = state_q;
    rec_d = rec_q;
    pend_d = pend_q;
    pend_seg_d = pend_seg_q;
    case (state_q)
      ST_OPCODE:
      begin
        if (take)
        begin
          rec_d = '0;
          rec_d.wide = b[0];
          rec_d.dir = b[1];
          if (is_prefix)
          begin
            rec_d.kind = KIND_SEG_PREFIX;
            rec_d.ovr_valid = 1'b1;
            rec_d.ovr_seg = seg_e'(b[4:3]);
            rec_d.wide = 1'b0;
            rec_d.dir = 1'b0;
            rec_d.cycles = CYC_PREFIX;
            pend_d = 1'b1;
            pend_seg_d = seg_e'(b[4:3]);
            state_d = ST_EMIT;
          end
          else if (is_flags)
          begin
            rec_d.kind = KIND_RESTORE_FLAGS;
            rec_d.wide = 1'b0;
            rec_d.dir = 1'b0;
            state_d = ST_COST;
          end
          else if (is_add_rm || is_adc_rm || is_sub_rm)
          begin
            rec_d.kind = is_add_rm ? KIND_ADD : (is_adc_rm ? KIND_ADC : KIND_SUB);
            rec_d.form = FORM_RM;
            state_d = ST_MODRM;
          end
          else if (is_grp)
          begin
            rec_d.kind = KIND_UNKNOWN;
            rec_d.form = FORM_IMM_RM;
            rec_d.sext = b[1];
            rec_d.dir = 1'b0;
            state_d = ST_MODRM;
          end
          else if (is_add_acc || is_adc_acc)
          begin
            rec_d.kind = is_add_acc ? KIND_ADD : KIND_ADC;
            rec_d.form = FORM_IMM_ACC;
            rec_d.dir = 1'b0;
            state_d = ST_IMM_LO;
          end
          else
          begin
            // not handled here, passed on as unknown
            rec_d.kind = KIND_UNKNOWN;
            rec_d.wide = 1'b0;
            rec_d.dir = 1'b0;
            state_d = ST_COST;
          end
        end
      end
      ST_MODRM:
      begin
        if (take)
        begin
          rec_d.mode = b[7:6];
          rec_d.reg_f = b[5:3];
          rec_d.rm = b[2:0];
          if (is_grp_rec)
          begin
            if (b[5:3] == GRP_ADC)
            begin
              rec_d.kind = KIND_ADC;
            end
            else if (b[5:3] == GRP_ADD)
            begin
              rec_d.kind = KIND_ADD;
            end
          end
          if (disp1 || disp2)
          begin
            state_d = ST_DISP_LO;
          end
          else
          begin
            state_d = is_grp_rec ? ST_IMM_LO : ST_COST;
          end
        end
      end
      ST_DISP_LO:
      begin
        if (take)
        begin
          // short displacement is sign extended
          rec_d.disp = {{8{b[7]}}, b};
          if (rec_disp2)
          begin
            state_d = ST_DISP_HI;
          end
          else
          begin
            state_d = is_grp_rec ? ST_IMM_LO : ST_COST;
          end
        end
      end
      ST_DISP_HI:
      begin
        if (take)
        begin
          rec_d.disp[15:8] = b;
          state_d = is_grp_rec ? ST_IMM_LO : ST_COST;
        end
      end
      ST_IMM_LO:
      begin
        if (take)
        begin
          // one byte, extended by sign if asked
          rec_d.imm = {(rec_q.sext && rec_q.wide) ? {8{b[7]}} : 8'h00, b};
          state_d = imm_two ? ST_IMM_HI : ST_COST;
        end
      end
      ST_IMM_HI:
      begin
        if (take)
        begin
          rec_d.imm[15:8] = b;
          state_d = ST_COST;
        end
      end
      ST_COST:
      begin
        // attach any waiting override, then price the instruction
        if (ce_i)
        begin
          rec_d.cycles = cost;
          rec_d.ovr_valid = pend_q;
          rec_d.ovr_seg = pend_seg_q;
          pend_d = 1'b0;
          state_d = ST_EMIT;
        end
      end
      ST_EMIT:
      begin
        if (emit_done)
        begin
          state_d = ST_OPCODE;
        end
      end
      default: state_d = ST_OPCODE;
    endcase
  end

  // state registers
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_OPCODE;
      rec_q <= '0;
      pend_q <= 1'b0;
      pend_seg_q <= SEG_EXTRA;
    end
    else if (ce_i)
    begin
      state_q <= state_d;
      rec_q <= rec_d;
      pend_q <= pend_d;
      pend_seg_q <= pend_seg_d;
    end
  end

  // control register and emitted count
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= CTRL_RESET;
      count_q <= 16'h0000;
    end
    else if (ce_i)
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= wb_dat_i[1:0];
      end
      // a write clears the count, an emit in the same cycle still counts
      if (emit_done)
      begin
        count_q <= wr_count ? 16'h0001 : 16'(count_q + 16'h0001);
      end
      else if (wr_count)
      begin
        count_q <= 16'h0000;
      end
    end
  end

  // read data selection
  wire [31:0] status_word = (32'(rec_q.cycles) << STAT_CYC_LSB)
                            | (32'(rec_q.kind) << STAT_KIND_LSB)
                            | (32'(pend_q) << STAT_PEND_BIT)
                            | (32'(state_q != ST_OPCODE) << STAT_BUSY_BIT);
  wire [31:0] rsel = (wb_adr_i == CTRL_OFS) ? {30'h0000_0000, ctrl_q}
                   : (wb_adr_i == STATUS_OFS) ? status_word
                   : (wb_adr_i == COUNT_OFS) ? {16'h0000, count_q}
                   : 32'h0000_0000;

  // bus answer one cycle after the request, unmapped reads give zero
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_q <= bus_req;
      if (bus_req && !wb_we_i)
      begin
        rdat_q <= rsel;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign byte_ready_o = enable && want_byte;
  assign dec_valid_o = (state_q == ST_EMIT);
  assign dec_o = rec_q;
endmodule : flag_stack_prefix_add_decode
`default_nettype wire

// File: shared/decode_pkg.sv
`default_nettype none
package decode_pkg;
  // wishbone register map, byte addresses of aligned words
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] COUNT_OFS = 4'h8;
  // control register fields and reset value
  localparam int CTRL_NARROW_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  // status register field positions
  localparam int STAT_CYC_LSB = 0;
  localparam int STAT_KIND_LSB = 8;
  localparam int STAT_PEND_BIT = 16;
  localparam int STAT_BUSY_BIT = 17;
  // opcode patterns
  localparam logic [7:0] OP_RESTORE_FLAGS = 8'h9d;
  localparam logic [5:0] OP_ADD_RM = 6'h00;
  localparam logic [5:0] OP_ADC_RM = 6'h04;
  localparam logic [5:0] OP_SUB_RM = 6'h0a;
  localparam logic [5:0] OP_IMM_GROUP = 6'h20;
  localparam logic [6:0] OP_ADD_ACC = 7'h02;
  localparam logic [6:0] OP_ADC_ACC = 7'h0a;
  localparam logic [7:0] OP_CODE_OVR = 8'h2e;
  localparam logic [7:0] OP_STACK_OVR = 8'h36;
  localparam logic [7:0] OP_DATA_OVR = 8'h3e;
  localparam logic [7:0] OP_EXTRA_OVR = 8'h26;
  // middle field of the addressing byte in the immediate group
  localparam logic [2:0] GRP_ADD = 3'h0;
  localparam logic [2:0] GRP_ADC = 3'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  // execution clock counts
  localparam logic [4:0] CYC_PREFIX = 5'h02;
  localparam logic [4:0] CYC_FLAGS_WIDE = 5'h08;
  localparam logic [4:0] CYC_FLAGS_NARROW = 5'h0c;
  localparam logic [4:0] CYC_RM_REG = 5'h03;
  localparam logic [4:0] CYC_RM_MEM = 5'h0a;
  localparam logic [4:0] CYC_IMM_REG = 5'h04;
  localparam logic [4:0] CYC_IMM_MEM = 5'h10;
  localparam logic [4:0] CYC_ACC_BYTE = 5'h03;
  localparam logic [4:0] CYC_ACC_WORD = 5'h04;
  localparam logic [4:0] CYC_NARROW_WORD = 5'h04;
  // decoded instruction classes
  typedef enum logic [2:0] {
    KIND_NONE, KIND_SEG_PREFIX, KIND_RESTORE_FLAGS,
    KIND_ADD, KIND_ADC, KIND_SUB, KIND_UNKNOWN
  } kind_e;
  // operand forms
  typedef enum logic [1:0] {FORM_NONE, FORM_RM, FORM_IMM_RM, FORM_IMM_ACC} form_e;
  // segment selected by a prefix, in opcode bit order
  typedef enum logic [1:0] {SEG_EXTRA, SEG_CODE, SEG_STACK, SEG_DATA} seg_e;
  // one decoded instruction handed to the execution unit
  typedef struct packed {
    kind_e kind;
    form_e form;
    logic ovr_valid;
    seg_e ovr_seg;
    logic wide;
    logic dir;
    logic sext;
    logic [1:0] mode;
    logic [2:0] reg_f;
    logic [2:0] rm;
    logic [15:0] disp;
    logic [15:0] imm;
    logic [4:0] cycles;
  } decoded_s;
endpackage : decode_pkg
`default_nettype wire

// File: tb/decode_checker.sv
`timescale 1ns/1ps
`default_nettype none
module decode_checker
  import decode_pkg::*;
(
  input wire logic clock_i, // clock
  input wire logic rst_i, // reset
  input wire logic ce_i, // enable
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_ack_o, // bus ack
  input wire logic byte_ready_o, // byte taken
  input wire decode_pkg::decoded_s dec_o, // record
  input wire logic dec_valid_o, // record present
  input wire logic dec_ready_i // record taken
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o && ce_i |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_flags;
    dec_valid_o && dec_o.kind == KIND_RESTORE_FLAGS |-> dec_o.cycles inside {5'h08, 5'h0c};
  endproperty
  a_flags: assert property (p_flags) else $error("flags count");
  property p_prefix;
    dec_valid_o && dec_o.kind == KIND_SEG_PREFIX |-> dec_o.cycles == 5'h02;
  endproperty
  a_prefix: assert property (p_prefix) else $error("prefix count");
  property p_rm_reg;
    dec_valid_o && dec_o.form == FORM_RM && dec_o.mode == 2'h3 |-> dec_o.cycles == 5'h03;
  endproperty
  a_rm_reg: assert property (p_rm_reg) else $error("reg form count");
  property p_imm_reg;
    dec_valid_o && dec_o.form == FORM_IMM_RM && dec_o.mode == 2'h3
      && dec_o.kind != KIND_UNKNOWN |-> dec_o.cycles == 5'h04;
  endproperty
  a_imm_reg: assert property (p_imm_reg) else $error("imm count");
  property p_acc;
    dec_valid_o && dec_o.form == FORM_IMM_ACC |-> dec_o.cycles == (dec_o.wide ? 5'h04 : 5'h03);
  endproperty
  a_acc: assert property (p_acc) else $error("acc count");
  property p_sext;
    dec_valid_o && dec_o.sext && dec_o.wide |-> dec_o.imm[15:8] == {8{dec_o.imm[7]}};
  endproperty
  a_sext: assert property (p_sext) else $error("sign extend");
  property p_hold;
    dec_valid_o && !(dec_ready_i && ce_i) |=> dec_valid_o && $stable(dec_o);
  endproperty
  a_hold: assert property (p_hold) else $error("record dropped");
  property p_busy;
    dec_valid_o |-> !byte_ready_o;
  endproperty
  a_busy: assert property (p_busy) else $error("byte taken in emit");
endmodule : decode_checker
bind flag_stack_prefix_add_decode decode_checker CHK (.clock_i(clock_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .byte_ready_o(byte_ready_o), .dec_o(dec_o), .dec_valid_o(dec_valid_o),
  .dec_ready_i(dec_ready_i));
`default_nettype wire

// File: tb/exec_unit_model.sv
`timescale 1ns/1ps
`default_nettype none
module exec_unit_model (
  input wire logic clock_i, // clock
  input wire logic rst_i, // reset
  input wire logic slow_i, // stall at random
  input wire logic dec_valid_i, // record present
  output logic dec_ready_o // record taken
);
  logic [7:0] lfsr_q; // stall pattern
  // a busy unit is ready in the cycles where the low two stall pattern bits are zero
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      lfsr_q <= 8'h5a;
    else
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end
  assign dec_ready_o = dec_valid_i && (!slow_i || lfsr_q[1:0] == 2'h0);
endmodule : exec_unit_model
`default_nettype wire

// File: tb/flag_stack_prefix_add_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flag_stack_prefix_add_decode_tb;
  import decode_pkg::*;
  logic clock_i = 0, rst_i = 1, ce_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = 0, wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q, r;
  logic [31:0] seed = 32'h0000_df4a;
  logic wb_ack_o, byte_ready_o, byte_valid_i = 0, dec_valid_o, dec_ready_i, slow = 0;
  logic narrow, pre;
  kind_e last_k;
  logic [4:0] last_c;
  logic [1:0] seg;
  logic [7:0] byte_i = 0;
  decoded_s dec_o;
  int bad_count = 0, checks = 0, count = 0;
  logic [7:0] ops [18] = '{8'h9d, 8'h2e, 8'h00, 8'h36, 8'h03, 8'h3e, 8'h10, 8'h26, 8'h13,
    8'h80, 8'h81, 8'h83, 8'h83, 8'h14, 8'h15, 8'h28, 8'h2b, 8'h82};
  logic [7:0] mods [18] = '{8'h00, 8'h00, 8'hc1, 8'h00, 8'h06, 8'h00, 8'hc0, 8'h00, 8'h45,
    8'hd0, 8'h96, 8'hd3, 8'h17, 8'h00, 8'h00, 8'hc8, 8'h86, 8'hc8};
  always #12.5 clock_i = ~clock_i;
  flag_stack_prefix_add_decode DUT (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .byte_i(byte_i), .byte_valid_i(byte_valid_i), .byte_ready_o(byte_ready_o),
    .dec_o(dec_o), .dec_valid_o(dec_valid_o), .dec_ready_i(dec_ready_i));
  exec_unit_model EU (.clock_i(clock_i), .rst_i(rst_i), .slow_i(slow),
    .dec_valid_i(dec_valid_o), .dec_ready_o(dec_ready_i));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // expected class and clock count of one instruction
  function automatic void exp_of(input logic [7:0] op, input logic [7:0] m,
    output kind_e k, output logic [4:0] c);
    logic mem, rm, grp, acc;
    mem = m[7:6] != 2'h3;
    rm = op[7:2] == 6'h00 || op[7:2] == 6'h04 || op[7:2] == 6'h0a;
    grp = op[7:2] == 6'h20 && (m[5:3] == 3'h0 || m[5:3] == 3'h2);
    acc = op[7:1] == 7'h02 || op[7:1] == 7'h0a;
    k = KIND_UNKNOWN;
    c = 5'h00;
    if (op == 8'h9d) begin k = KIND_RESTORE_FLAGS; c = narrow ? 5'h0c : 5'h08; end
    if (op[7:5] == 3'h1 && op[2:0] == 3'h6) begin k = KIND_SEG_PREFIX; c = 5'h02; end
    if (rm) c = mem ? 5'h0a : 5'h03;
    if (grp) c = mem ? 5'h10 : 5'h04;
    if (acc) c = op[0] ? 5'h04 : 5'h03;
    if ((rm || grp) && narrow && mem && op[0]) c = c + 5'h04;
    if ((rm && op[7:2] == 6'h00) || op[7:1] == 7'h02 || (grp && m[5:3] == 3'h0)) k = KIND_ADD;
    if ((rm && op[7:2] == 6'h04) || op[7:1] == 7'h0a || (grp && m[5:3] == 3'h2)) k = KIND_ADC;
    if (rm && op[7:2] == 6'h0a) k = KIND_SUB;
  endfunction : exp_of
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task too_long(input int n);
    if (n >= 50)
    begin
      bad_count++;
      end_of_test();
    end
  endtask : too_long
  // classic single cycle, held until ack is sampled
  task wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin @(posedge clock_i); n++; end while (wb_ack_o !== 1 && n < 50);
    too_long(n);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clock_i);
  endtask : wb
  task put(input logic [7:0] b);
    int n;
    n = 0;
    byte_i <= b;
    byte_valid_i <= 1;
    do begin @(posedge clock_i); n++; end while (byte_ready_o !== 1 && n < 50);
    too_long(n);
  endtask : put
  task run(input logic [7:0] op, input logic [7:0] m);
    int n;
    kind_e k;
    logic [4:0] c;
    logic modrm, grp;
    modrm = op[7:2] inside {6'h00, 6'h04, 6'h0a, 6'h20};
    grp = op[7:2] == 6'h20;
    put(op);
    n = 0;
    if (modrm)
    begin
      put(m);
      n = m[7:6] == 2'h1 ? 1 : (m[7:6] == 2'h2 || (m[7:6] == 2'h0 && m[2:0] == 3'h6)) ? 2 : 0;
    end
    if (grp) n += (!op[0] || op[1]) ? 1 : 2;
    if (op[7:1] == 7'h02 || op[7:1] == 7'h0a) n = op[0] ? 2 : 1;
    repeat (n) begin r = rnd(); put(r[7:0]); end
    byte_valid_i <= 0;
    n = 0;
    do begin @(posedge clock_i); n++; end while (dec_valid_o !== 1 && n < 50);
    too_long(n);
    exp_of(op, m, k, c);
    chk("kind", k, dec_o.kind);
    chk("cycles", c, dec_o.cycles);
    if (k inside {KIND_ADD, KIND_ADC, KIND_SUB}) chk("wide", op[0], dec_o.wide);
    if (modrm && !grp && k != KIND_UNKNOWN) chk("dir", op[1], dec_o.dir);
    if (k != KIND_SEG_PREFIX) chk("override", pre, dec_o.ovr_valid);
    if (k != KIND_SEG_PREFIX && pre) chk("segment", seg, dec_o.ovr_seg);
    pre = k == KIND_SEG_PREFIX;
    seg = op[4:3];
    count++;
    last_k = k;
    last_c = c;
    n = 0;
    while (dec_valid_o === 1 && n < 50) begin @(posedge clock_i); n++; end
    too_long(n);
  endtask : run
  initial
  begin
    int w;
    repeat (20) @(posedge clock_i);
    rst_i <= 0;
    wb(0, 4'h0, 0);
    chk("ctrl reset", 32'h0000_0002, q);
    wb(0, 4'hc, 0);
    chk("unmapped", 32'h0000_0000, q);
    // an override left pending carries over from one bus variant to the next
    pre = 0;
    for (int v = 0; v < 2; v++)
    begin
      narrow = v[0];
      slow <= v[0];
      wb(1, 4'h0, {30'h0, 1'b1, narrow});
      foreach (ops[i]) run(ops[i], mods[i]);
      repeat (60) begin r = rnd(); run(ops[r[31:16] % 18], r[15:8]); end
    end
    wb(0, 4'h4, 0);
    r = (32'(pre) << STAT_PEND_BIT) | (32'(last_k) << STAT_KIND_LSB) | 32'(last_c);
    chk("status", r, q);
    wb(0, 4'h8, 0);
    chk("count", count, q);
    // frozen clock enable: a held request gets no answer until it returns
    ce_i <= 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= 0;
    repeat (3) @(posedge clock_i);
    chk("frozen ack", 0, wb_ack_o);
    ce_i <= 1;
    w = 0;
    do begin @(posedge clock_i); w++; end while (wb_ack_o !== 1 && w < 50);
    too_long(w);
    chk("thawed read", count, wb_dat_o);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clock_i);
    wb(1, 4'h8, 0);
    wb(0, 4'h8, 0);
    chk("count cleared", 0, q);
    // disabled decoder refuses bytes
    wb(1, 4'h0, 0);
    byte_valid_i <= 1;
    repeat (2) @(posedge clock_i);
    chk("refused", 0, byte_ready_o);
    end_of_test();
  end
endmodule : flag_stack_prefix_add_decode_tb
`default_nettype wire
